// ---- common/ipc_map.vh ----
// register indices, reset values and field layout of the infrared configuration bank
`ifndef IPC_MAP_VH
`define IPC_MAP_VH

// register indices; byte address on the bus is four times the index
`define IPC_IDX_DEVNUM     8'h07
`define IPC_IDX_MODE       8'h08
`define IPC_IDX_BASE1_HI   8'h60
`define IPC_IDX_BASE1_LO   8'h61
`define IPC_IDX_BASE2_HI   8'h62
`define IPC_IDX_BASE2_LO   8'h63
`define IPC_IDX_LVL1       8'h70
`define IPC_IDX_TYPE1      8'h71
`define IPC_IDX_LVL2       8'h72
`define IPC_IDX_TYPE2      8'h73
`define IPC_IDX_DMA1       8'h74
`define IPC_IDX_DMA2       8'h75
`define IPC_IDX_SPECIAL    8'hF0

// logical device number that exposes the infrared bank
`define IPC_DEVNUM_INFRARED 8'h04

// reset values
`define IPC_RST_DEVNUM     8'h00
`define IPC_RST_MODE       8'h01
`define IPC_RST_BASE1_HI   8'h02
`define IPC_RST_BASE1_LO   8'hE8
`define IPC_RST_BASE2_HI   8'h03
`define IPC_RST_BASE2_LO   8'h00
`define IPC_RST_LVL1       8'h0A
`define IPC_RST_LVL2       8'h0B
`define IPC_RST_DMA1       8'h01
`define IPC_RST_DMA2       8'h00
`define IPC_RST_SPECIAL    8'h00
`define IPC_VAL_IRQ_TYPE   8'h02

// writable bit masks
`define IPC_MSK_DEVNUM     8'hFF
`define IPC_MSK_MODE       8'h01
`define IPC_MSK_BASE_HI    8'h0F
`define IPC_MSK_BASE_LO    8'hF8
`define IPC_MSK_LVL        8'h0F
`define IPC_MSK_DMA        8'h07
`define IPC_MSK_SPECIAL    8'h3F

// decode limits
`define IPC_IRQ_MAX        4'hB
`define IPC_IRQ_MIN        4'h3
`define IPC_IRQ_NONE       4'h0
`define IPC_DMA_NONE       3'h4

// special configuration bit positions
`define IPC_SP_SHARE       5
`define IPC_SP_ASK         4
`define IPC_SP_HALF        3
`define IPC_SP_DUALDMA     2
`define IPC_SP_DUALIRQ     1
`define IPC_SP_TWOIN       0

// mode register bit: motherboard autoconfig mode
`define IPC_MODE_MB        0

// bus responses
`define IPC_RESP_OKAY      2'h0
`define IPC_RESP_SLVERR    2'h2

`endif

// ---- sim/ipc_config_props.sv ----
// assertion checker for the infrared configuration bank ports
`timescale 1ns/1ps
module ipc_config_props #(
	parameter ADDR_W = 12
) (
	input wire        clk,
	input wire        reset,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [15:0] baseAddr1,
	input wire [15:0] baseAddr2,
	input wire [3:0]  irqNum1,
	input wire        irqValid1,
	input wire        irqShared,
	input wire        twoInputTransceiver,
	input wire        motherboardAutoconfigMode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// both valids rise together and both readies are high when idle, so both write halves land on one edge
	sequence writeTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence readTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	// bus timing and holding
	write_answer_a: assert property (writeTaken |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	read_answer_a: assert property (readTaken |=> s_axi_rvalid)
		else $error("read data missing");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data changed");
	rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read upper bits set");
	////////////////////////////////////////////////////////////////////////////////
	// fixed bits and decodes of the configuration outputs
	base_one_fixed_a: assert property (baseAddr1[15:12] == 4'h0 && baseAddr1[2:0] == 3'h0)
		else $error("base one fixed bits set");
	base_two_fixed_a: assert property (baseAddr2[15:12] == 4'h0 && baseAddr2[2:0] == 3'h0)
		else $error("base two fixed bits set");
	irq_valid_a: assert property (irqValid1 == (irqNum1 >= 4'h3 && irqNum1 <= 4'hB))
		else $error("interrupt valid decode wrong");
	special_gate_a: assert property (!motherboardAutoconfigMode |-> !irqShared && !twoInputTransceiver)
		else $error("special outputs active in add-in mode");
endmodule // ipc_config_props

// ---- sim/ipc_config_tb.sv ----
// self-checking bench for the infrared configuration bank
`timescale 1ns/1ps
module testbench;
	logic        clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp, dmaChan1, dmaChan2;
	wire  [31:0] s_axi_rdata;
	wire  [15:0] baseAddr1, baseAddr2;
	wire  [3:0]  irqNum1, irqNum2;
	wire         irqValid1, irqValid2, dmaValid1, dmaValid2, motherboardAutoconfigMode;
	wire         irqShared, amplitudeKeyedInfrared, halfDuplex, dualDma, dualIrq, twoInputTransceiver;
	wire  [5:0]  spc = {irqShared, amplitudeKeyedInfrared, halfDuplex, dualDma, dualIrq, twoInputTransceiver};
	integer      miscompares = 0, checks = 0, cycles = 0, i;
	logic [7:0]  v;
	// index, reset value, readback after writing all ones
	logic [23:0] regTab [0:10] = '{24'h60020F, 24'h61E8F8, 24'h62030F, 24'h6300F8, 24'h700A0F,
		24'h710202, 24'h720B0F, 24'h730202, 24'h740107, 24'h750007, 24'hF0003F};
	ipc_config_regs ipc_config_regs_inst (.*);
	////////////////////////////////////////////////////////////////////////////////
	// clock and watchdog; a hang counts as a miscompare
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// a full run takes about four hundred cycles; fifty times that is a hang
	always @(posedge clk)
	begin
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			miscompares = miscompares + 1;
			complete_run;
		end
	end
	task complete_run;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [39:0] g, input logic [39:0] e);
		checks = checks + 1;
		if (g !== e)
		begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// bus tasks: readies are judged settled at the falling edge, taken at the next rise
	task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic awGo, wGo, awDone, wDone;
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		awDone = 1'b0;
		wDone = 1'b0;
		// each channel is released at the edge that takes it, in either order
		while (!(awDone && wDone))
		begin
			@(negedge clk);
			awGo = s_axi_awvalid && s_axi_awready;
			wGo = s_axi_wvalid && s_axi_wready;
			@(posedge clk);
			if (awGo)
			begin
				s_axi_awvalid <= 1'b0;
				awDone = 1'b1;
			end
			if (wGo)
			begin
				s_axi_wvalid <= 1'b0;
				wDone = 1'b1;
			end
		end
		// bready comes late on purpose, so the response must hold a cycle
		@(negedge clk);
		while (s_axi_bvalid !== 1'b1) @(negedge clk);
		@(posedge clk);
		s_axi_bready <= 1'b1;
		@(negedge clk);
		chk(s_axi_bresp, er);
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		@(negedge clk);
		while (s_axi_arready !== 1'b1) @(negedge clk);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		// rready also comes late, so read data must hold a cycle
		@(negedge clk);
		while (s_axi_rvalid !== 1'b1) @(negedge clk);
		@(posedge clk);
		s_axi_rready <= 1'b1;
		@(negedge clk);
		chk({s_axi_rdata, s_axi_rresp}, {24'h0, ed, er});
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		reset <= 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 56'h0;
		s_axi_wstrb <= 4'hF;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		chk({baseAddr1, baseAddr2}, 32'h02E80300);
		rd(8'h60, 8'h00, 2'h2);
		wr(8'h07, 8'h04, 2'h0);
		for (i = 0; i < 11; i++) rd(regTab[i][23:16], regTab[i][15:8], 2'h0);
		// all ones exposes every fixed and reserved bit at once
		for (i = 0; i < 11; i++)
		begin
			wr(regTab[i][23:16], 8'hFF, 2'h0);
			rd(regTab[i][23:16], regTab[i][7:0], 2'h0);
		end
		chk({baseAddr1, baseAddr2, spc}, {32'h0FF80FF8, 6'h3F});
		// a cleared low lane answers okay and leaves the register alone
		s_axi_wstrb <= 4'hE;
		wr(8'h63, 8'h00, 2'h0);
		chk(baseAddr2, 16'h0FF8);
		s_axi_wstrb <= 4'hF;
		wr(8'h60, 8'hA5, 2'h0);
		wr(8'h61, 8'h5D, 2'h0);
		chk(baseAddr1, 16'h0558);
		for (i = 0; i < 16; i++)
		begin
			v = i;
			wr(8'h70, v, 2'h0);
			wr(8'h72, v, 2'h0);
			chk({irqNum1, irqValid1, irqNum2, irqValid2}, {2{v[3:0], v >= 3 && v <= 11}});
		end
		for (i = 0; i < 8; i++)
		begin
			v = i;
			wr(8'h74, v, 2'h0);
			wr(8'h75, v, 2'h0);
			chk({dmaChan1, dmaValid1, dmaChan2, dmaValid2}, {2{v[1:0], v < 4}});
		end
		for (i = 0; i < 6; i++)
		begin
			wr(8'hF0, 8'h01 << i, 2'h0);
			chk(spc, 6'h01 << i);
		end
		// add-in mode hides the special register and gates its outputs
		wr(8'h08, 8'h00, 2'h0);
		chk({motherboardAutoconfigMode, spc}, 7'h00);
		rd(8'hF0, 8'h00, 2'h2);
		wr(8'hF0, 8'h01, 2'h2);
		wr(8'h08, 8'h01, 2'h0);
		chk(spc, 6'h20);
		rd(8'h40, 8'h00, 2'h2);
		wr(8'h07, 8'h05, 2'h0);
		rd(8'h61, 8'h00, 2'h2);
		wr(8'h61, 8'h00, 2'h2);
		chk(baseAddr1, 16'h0558);
		// a second reset restores every default and hides the bank again
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		chk({baseAddr1, baseAddr2, spc, motherboardAutoconfigMode}, {32'h02E80300, 7'h01});
		chk({irqNum1, irqValid1, irqNum2, irqValid2, dmaChan1, dmaValid1, dmaChan2, dmaValid2},
			{4'hA, 1'b1, 4'hB, 1'b1, 2'h1, 1'b1, 2'h0, 1'b1});
		rd(8'h60, 8'h00, 2'h2);
		complete_run;
	end
endmodule // testbench
bind ipc_config_regs ipc_config_props #(.ADDR_W(ADDR_W)) ipc_config_props_inst (.*);

// ---- verilog/ipc_config_regs.v ----
// infrared port configuration register bank behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "ipc_map.vh"

// Overview of operation
// - Infrared bank visible only when device 04h selected
// - Base1 high: bits 3-0 stored, reset 02h
// - Base1 low: bits 7-3 stored, reset E8h
// - Base2 same layout, reset 03h and 00h
// - Level1 nibble is request number, reset 0Ah
// - Level2 same encoding, reset 0Bh
// - Both interrupt types read fixed 02h
// - DMA1 bits 2-0 channel, 4h none, reset 01h
// - DMA2 same encoding, reset 00h
// - Special register bits 5-0, motherboard mode only
// - Bit 5 selects shared interrupt output
// - Bit 4 selects amplitude-keyed slow infrared
// - Bit 3 selects half duplex slow infrared
// - Bit 2 selects dual DMA channels
// - Bit 1 selects dual interrupt levels
// - Bit 0 selects two-input fast transceiver
module ipc_config_regs #(
	parameter ADDR_W = 12
) (
	input  wire              clk,
	input  wire              reset,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	output wire [1:0]        s_axi_bresp,
	output wire              s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output wire [31:0]       s_axi_rdata,
	output wire [1:0]        s_axi_rresp,
	output wire              s_axi_rvalid,
	input  wire              s_axi_rready,
	output wire [15:0]       baseAddr1,
	output wire [15:0]       baseAddr2,
	output wire [3:0]        irqNum1,
	output wire              irqValid1,
	output wire [3:0]        irqNum2,
	output wire              irqValid2,
	output wire [1:0]        dmaChan1,
	output wire              dmaValid1,
	output wire [1:0]        dmaChan2,
	output wire              dmaValid2,
	output wire              irqShared,
	output wire              amplitudeKeyedInfrared,
	output wire              halfDuplex,
	output wire              dualDma,
	output wire              dualIrq,
	output wire              twoInputTransceiver,
	output wire              motherboardAutoconfigMode
);

////////////////////////////////////////////////////////////////////////////////
// storage
reg [7:0]        logicalDeviceNumber_r;
reg [7:0]        mode_r;
reg [7:0]        base1Hi_r;
reg [7:0]        base1Lo_r;
reg [7:0]        base2Hi_r;
reg [7:0]        base2Lo_r;
reg [7:0]        lvl1_r;
reg [7:0]        lvl2_r;
reg [7:0]        dma1_r;
reg [7:0]        dma2_r;
reg [7:0]        special_r;

reg              awHeld_r;
reg [ADDR_W-1:0] awAddr_r;
reg              wHeld_r;
reg [7:0]        wData_r;
reg              wLane_r;
reg              bValid_r;
reg [1:0]        bResp_r;
reg              rValid_r;
reg [31:0]       rData_r;
reg [1:0]        rResp_r;

wire [7:0]       wIdx;
wire             wMapped;
wire             doWrite;
wire             wEn;
wire [7:0]       rIdx;

////////////////////////////////////////////////////////////////////////////////
// helpers

// an address is mapped only within the decoded window and for visible indices
function mapped;
	input [ADDR_W-1:0] addr;
	input [7:0]        devNum;
	input              mb;
	reg   [7:0]        idx;
	reg                irSel;
	begin
		idx = addr[9:2];
		irSel = (devNum == `IPC_DEVNUM_INFRARED);
		mapped = 1'b0;
		if (addr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}})
		begin
			case (idx)
				`IPC_IDX_DEVNUM,
				`IPC_IDX_MODE:     mapped = 1'b1;
				`IPC_IDX_BASE1_HI,
				`IPC_IDX_BASE1_LO,
				`IPC_IDX_BASE2_HI,
				`IPC_IDX_BASE2_LO,
				`IPC_IDX_LVL1,
				`IPC_IDX_TYPE1,
				`IPC_IDX_LVL2,
				`IPC_IDX_TYPE2,
				`IPC_IDX_DMA1,
				`IPC_IDX_DMA2:     mapped = irSel;
				`IPC_IDX_SPECIAL: mapped = irSel & mb;
				default: mapped = 1'b0;
			endcase
		end
	end
endfunction

// masked update keeps fixed bits at their reset value
function [7:0] merge;
	input [7:0] old;
	input [7:0] data;
	input [7:0] mask;
	begin
		merge = (old & ~mask) | (data & mask);
	end
endfunction

// request lines 3 to 11 are the only real choices
function irqOk;
	input [3:0] n;
	begin
		irqOk = (n >= `IPC_IRQ_MIN) && (n <= `IPC_IRQ_MAX);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// write channel: address and data taken in either order, one write in flight
assign s_axi_awready = ~awHeld_r & ~bValid_r;
assign s_axi_wready  = ~wHeld_r & ~bValid_r;
assign s_axi_bvalid  = bValid_r;
assign s_axi_bresp   = bResp_r;
assign wIdx          = awAddr_r[9:2];
assign wMapped       = mapped(awAddr_r, logicalDeviceNumber_r, mode_r[`IPC_MODE_MB]);
assign doWrite       = awHeld_r & wHeld_r & ~bValid_r;
assign wEn           = doWrite & wMapped & wLane_r;

always @(posedge clk or posedge reset)
begin
	if (reset)
	begin
		awHeld_r <= 1'b0;
		awAddr_r <= {ADDR_W{1'b0}};
		wHeld_r  <= 1'b0;
		wData_r  <= 8'h00;
		wLane_r  <= 1'b0;
		bValid_r <= 1'b0;
		bResp_r  <= `IPC_RESP_OKAY;
	end
	else
	begin
		if (s_axi_awvalid && s_axi_awready)
		begin
			awHeld_r <= 1'b1;
			awAddr_r <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			wHeld_r <= 1'b1;
			wData_r <= s_axi_wdata[7:0];
			wLane_r <= s_axi_wstrb[0]; // only the low lane carries register bits
		end
		if (doWrite)
		begin
			awHeld_r <= 1'b0;
			wHeld_r  <= 1'b0;
			bValid_r <= 1'b1;
			bResp_r  <= wMapped ? `IPC_RESP_OKAY : `IPC_RESP_SLVERR;
		end
		else if (bValid_r && s_axi_bready)
			bValid_r <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// own registers: device selector and autoconfig mode bit
always @(posedge clk or posedge reset)
begin
	if (reset)
	begin
		logicalDeviceNumber_r <= `IPC_RST_DEVNUM;
		mode_r                <= `IPC_RST_MODE;
	end
	else if (wEn)
	begin
		case (wIdx)
			`IPC_IDX_DEVNUM:
				logicalDeviceNumber_r <= merge(logicalDeviceNumber_r, wData_r, `IPC_MSK_DEVNUM);
			`IPC_IDX_MODE:
				mode_r <= merge(mode_r, wData_r, `IPC_MSK_MODE);
			default:
				mode_r <= mode_r; // other indices belong to the processes below
		endcase
	end
end

// base addresses; low three bits stay zero to keep eight-byte alignment
always @(posedge clk or posedge reset)
begin
	if (reset)
	begin
		base1Hi_r <= `IPC_RST_BASE1_HI;
		base1Lo_r <= `IPC_RST_BASE1_LO;
		base2Hi_r <= `IPC_RST_BASE2_HI;
		base2Lo_r <= `IPC_RST_BASE2_LO;
	end
	else if (wEn)
	begin
		case (wIdx)
			`IPC_IDX_BASE1_HI:
				base1Hi_r <= merge(base1Hi_r, wData_r, `IPC_MSK_BASE_HI);
			`IPC_IDX_BASE1_LO:
				base1Lo_r <= merge(base1Lo_r, wData_r, `IPC_MSK_BASE_LO);
			`IPC_IDX_BASE2_HI:
				base2Hi_r <= merge(base2Hi_r, wData_r, `IPC_MSK_BASE_HI);
			`IPC_IDX_BASE2_LO:
				base2Lo_r <= merge(base2Lo_r, wData_r, `IPC_MSK_BASE_LO);
			default:
				base1Hi_r <= base1Hi_r;
		endcase
	end
end

// levels, dma selects and special bits; the type registers take no write
always @(posedge clk or posedge reset)
begin
	if (reset)
	begin
		lvl1_r    <= `IPC_RST_LVL1;
		lvl2_r    <= `IPC_RST_LVL2;
		dma1_r    <= `IPC_RST_DMA1;
		dma2_r    <= `IPC_RST_DMA2;
		special_r <= `IPC_RST_SPECIAL;
	end
	else if (wEn)
	begin
		case (wIdx)
			`IPC_IDX_LVL1:
				lvl1_r <= merge(lvl1_r, wData_r, `IPC_MSK_LVL);
			`IPC_IDX_LVL2:
				lvl2_r <= merge(lvl2_r, wData_r, `IPC_MSK_LVL);
			`IPC_IDX_DMA1:
				dma1_r <= merge(dma1_r, wData_r, `IPC_MSK_DMA);
			`IPC_IDX_DMA2:
				dma2_r <= merge(dma2_r, wData_r, `IPC_MSK_DMA);
			`IPC_IDX_SPECIAL:
				special_r <= merge(special_r, wData_r, `IPC_MSK_SPECIAL);
			default:
				lvl1_r <= lvl1_r;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// read channel: one cycle from address to data, held until rready
assign s_axi_arready = ~rValid_r;
assign s_axi_rvalid  = rValid_r;
assign s_axi_rdata   = rData_r;
assign s_axi_rresp   = rResp_r;
assign rIdx          = s_axi_araddr[9:2];

always @(posedge clk or posedge reset)
begin
	if (reset)
	begin
		rValid_r <= 1'b0;
		rData_r  <= 32'h00000000;
		rResp_r  <= `IPC_RESP_OKAY;
	end
	else if (s_axi_arvalid && s_axi_arready)
	begin
		rValid_r <= 1'b1;
		rData_r  <= 32'h00000000;
		rResp_r  <= `IPC_RESP_SLVERR;
		if (mapped(s_axi_araddr, logicalDeviceNumber_r, mode_r[`IPC_MODE_MB]))
		begin
			rResp_r <= `IPC_RESP_OKAY;
			case (rIdx)
				`IPC_IDX_DEVNUM:   rData_r[7:0] <= logicalDeviceNumber_r;
				`IPC_IDX_MODE:     rData_r[7:0] <= mode_r;
				`IPC_IDX_BASE1_HI: rData_r[7:0] <= base1Hi_r;
				`IPC_IDX_BASE1_LO: rData_r[7:0] <= base1Lo_r;
				`IPC_IDX_BASE2_HI: rData_r[7:0] <= base2Hi_r;
				`IPC_IDX_BASE2_LO: rData_r[7:0] <= base2Lo_r;
				`IPC_IDX_LVL1:     rData_r[7:0] <= lvl1_r;
				`IPC_IDX_LVL2:     rData_r[7:0] <= lvl2_r;
				`IPC_IDX_TYPE1:    rData_r[7:0] <= `IPC_VAL_IRQ_TYPE;
				`IPC_IDX_TYPE2:    rData_r[7:0] <= `IPC_VAL_IRQ_TYPE;
				`IPC_IDX_DMA1:     rData_r[7:0] <= dma1_r;
				`IPC_IDX_DMA2:     rData_r[7:0] <= dma2_r;
				`IPC_IDX_SPECIAL:  rData_r[7:0] <= special_r;
				default:           rData_r[7:0] <= 8'h00;
			endcase
		end
	end
	else if (rValid_r && s_axi_rready)
		rValid_r <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// configuration presented to the port logic
assign baseAddr1 = {base1Hi_r, base1Lo_r};
assign baseAddr2 = {base2Hi_r, base2Lo_r};
assign irqNum1   = lvl1_r[3:0];
assign irqValid1 = irqOk(lvl1_r[3:0]);
assign irqNum2   = lvl2_r[3:0];
assign irqValid2 = irqOk(lvl2_r[3:0]);
assign dmaChan1  = dma1_r[1:0];
assign dmaValid1 = (dma1_r[2:0] < `IPC_DMA_NONE);
assign dmaChan2  = dma2_r[1:0];
assign dmaValid2 = (dma2_r[2:0] < `IPC_DMA_NONE);

// special bits only take effect in motherboard mode, else plain defaults
assign irqShared              = mode_r[`IPC_MODE_MB] & special_r[`IPC_SP_SHARE];
assign amplitudeKeyedInfrared = mode_r[`IPC_MODE_MB] & special_r[`IPC_SP_ASK];
assign halfDuplex             = mode_r[`IPC_MODE_MB] & special_r[`IPC_SP_HALF];
assign dualDma                = mode_r[`IPC_MODE_MB] & special_r[`IPC_SP_DUALDMA];
assign dualIrq                = mode_r[`IPC_MODE_MB] & special_r[`IPC_SP_DUALIRQ];
assign twoInputTransceiver    = mode_r[`IPC_MODE_MB] & special_r[`IPC_SP_TWOIN];
assign motherboardAutoconfigMode = mode_r[`IPC_MODE_MB];

endmodule // ipc_config_regs
